/* File: hdl/tpm_cfg.svh */
// Timing counts and limits for the touch power-mode block.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH
`define TPM_CLK_MHZ        200
`define TPM_CYC_PER_MS     (`TPM_CLK_MHZ * 1000)
`define TPM_NORM_MIN_MS    7
`define TPM_NORM_MAX_MS    10
`define TPM_GREEN_MS       40
`define TPM_IDLE_MAX_S     15
`define TPM_WAKE_MIN_MS    2
`define TPM_WAKE_MAX_MS    5
`define TPM_BASE_INIT_MS   200
`define TPM_INT_PULSE_CYC  16
`define TPM_HOP_NOISE_LIM  3
`endif

/* File: hdl/tpm_pkg.sv */
// Types for the touch power-mode block.
// No assumptions beyond a SystemVerilog compiler.
package tpm_pkg;
    // Gray along Normal -> Green -> Sleep
    typedef enum logic [1:0] {
        TPM_NORMAL = 2'b00,
        TPM_GREEN  = 2'b01,
        TPM_SLEEP  = 2'b11
    } tpm_mode_e;
endpackage

/* File: hdl/tpm_power_notify.sv */
// Power-mode sequencer, scan pacing, calibration and host notification of a touch controller.
// Assumes the touch front end reports results on core_clk; int pin comes from the host pads.
// What this block does
// - Normal mode scans every configured 7..10 ms
// - No touch for idle seconds enters Green
// - Green mode scans every fixed 40 ms
// - Touch in Green returns to Normal
// - Sleep command enters Sleep mode
// - Interrupt held high 2..5 ms wakes
// - Notify host only on touch events
// - Trigger bit: 0 rising, 1 falling edge
// - Noise in band hops drive frequency
// - Baseline copied from first touch-free scan within 200 ms after start
// - Track drift by comparing history and current
`timescale 1ns/1ps
`include "tpm_cfg.svh"
module tpm_power_notify #(
    parameter int  NORM_MIN_CYC  = `TPM_NORM_MIN_MS * `TPM_CYC_PER_MS,  // Shortest Normal period
    parameter int  NORM_STEP_CYC = `TPM_CYC_PER_MS,                     // Per-step period increase
    parameter int  GREEN_CYC     = `TPM_GREEN_MS * `TPM_CYC_PER_MS,     // Green scan period
    parameter int  SEC_CYC       = 1000 * `TPM_CYC_PER_MS,              // One second
    parameter int  WAKE_MIN_CYC  = `TPM_WAKE_MIN_MS * `TPM_CYC_PER_MS,  // Least wake pulse
    parameter int  WAKE_MAX_CYC  = `TPM_WAKE_MAX_MS * `TPM_CYC_PER_MS,  // Longest wake pulse
    parameter int  BASE_INIT_CYC = `TPM_BASE_INIT_MS * `TPM_CYC_PER_MS, // Initial calibration window
    parameter int  SAMPLE_W      = 16,                                  // Sensor sample width
    parameter int  FREQ_W        = 3                                    // Drive frequency index width
) (
    input  wire logic                core_clk,      // 200 MHz clock
    input  wire logic                sys_rst,       // Synchronous reset, active high
    input  wire logic                clk_en,        // Freezes all state while low
    input  wire logic [1:0]          scan_period,   // Normal period select 0..3 (7..10 ms)
    input  wire logic [3:0]          idle_secs,     // No-touch seconds before Green
    input  wire logic                int_trigger,   // 0 rising, 1 falling notification
    input  wire logic                sleep_cmd,     // One-cycle sleep command from bus decoder
    input  wire logic                scan_done,     // One-cycle: scan result valid
    input  wire logic                touch_seen,    // With scan_done: touch present
    input  wire logic                noise_hit,     // With scan_done: noise in drive band
    input  wire logic [SAMPLE_W-1:0] sample_raw,    // With scan_done: raw sensor level
    input  wire logic                int_in,        // Interrupt pin level from pad
    output logic                     int_out,       // Interrupt pin drive value
    output logic                     int_oe,        // Interrupt pin drive enable
    output logic                     scan_start,    // One-cycle scan request
    output logic [FREQ_W-1:0]        drive_freq,    // Selected drive frequency
    output logic [SAMPLE_W-1:0]      baseline,      // Current baseline
    output logic                     base_ready,    // Initial baseline taken or init window ended
    output logic [1:0]               mode_out       // Current power mode
);

    tpm_pkg::tpm_mode_e mode_reg;                   // Power mode
    logic               int_s1_reg;                 // Pin synchroniser stage 1
    logic               int_s2_reg;                 // Pin synchroniser stage 2
    logic [31:0]        scan_cnt_reg;               // Scan period counter
    logic [31:0]        sec_cnt_reg;                // One-second prescaler
    logic [3:0]         idle_cnt_reg;               // Seconds without touch
    logic [31:0]        wake_cnt_reg;               // Length of high pulse on pin
    logic               wake_fire;                  // Valid wake pulse ended
    logic [31:0]        scan_limit;                 // Active scan period
    logic [31:0]        init_cnt_reg;               // Time since reset
    logic [1:0]         noise_cnt_reg;              // Consecutive noisy scans
    logic [4:0]         pulse_cnt_reg;              // Notification pulse timer
    logic               notify;                     // Touch event to report

    assign mode_out = mode_reg;

    // Two-flop synchroniser for the host-driven interrupt pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_s1_reg <= 1'b0;
            int_s2_reg <= 1'b0;
        end else if (clk_en) begin
            int_s1_reg <= int_in;
            // Only this stage reads stage 1; all other logic sees stage 2
            int_s2_reg <= int_s1_reg;
        end
    end

    // Wake pulse width: only 2..5 ms high counts, longer or shorter ignored
    assign wake_fire = (mode_reg == tpm_pkg::TPM_SLEEP) && !int_s2_reg &&
                       (wake_cnt_reg >= 32'(WAKE_MIN_CYC)) && (wake_cnt_reg <= 32'(WAKE_MAX_CYC));

    // Count high time on the pin while asleep; saturate to avoid wrap
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_cnt_reg <= 32'h0;
        end else if (clk_en) begin
            if (mode_reg != tpm_pkg::TPM_SLEEP || !int_s2_reg) begin
                wake_cnt_reg <= 32'h0;
            end else if (wake_cnt_reg <= 32'(WAKE_MAX_CYC)) begin
                wake_cnt_reg <= wake_cnt_reg + 32'h1;
            end
        end
    end

    // Scan period chosen by mode
    always_comb begin
        if (mode_reg == tpm_pkg::TPM_GREEN) begin
            scan_limit = 32'(GREEN_CYC);
        end else begin
            scan_limit = 32'(NORM_MIN_CYC) + 32'(NORM_STEP_CYC) * 32'(scan_period);
        end
    end

    // Scan pacing; stopped during Sleep
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scan_cnt_reg <= 32'h0;
            scan_start   <= 1'b0;
        end else if (clk_en) begin
            scan_start <= 1'b0;
            if (mode_reg == tpm_pkg::TPM_SLEEP) begin
                scan_cnt_reg <= 32'h0;
            end else if (scan_cnt_reg >= scan_limit - 32'h1) begin
                scan_cnt_reg <= 32'h0;
                scan_start   <= 1'b1;
            end else begin
                scan_cnt_reg <= scan_cnt_reg + 32'h1;
            end
        end
    end

    // No-touch seconds in Normal mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sec_cnt_reg  <= 32'h0;
            idle_cnt_reg <= 4'h0;
        end else if (clk_en) begin
            if (mode_reg != tpm_pkg::TPM_NORMAL || (scan_done && touch_seen)) begin
                sec_cnt_reg  <= 32'h0;
                idle_cnt_reg <= 4'h0;
            end else if (sec_cnt_reg >= 32'(SEC_CYC) - 32'h1) begin
                sec_cnt_reg <= 32'h0;
                if (idle_cnt_reg != 4'hf) begin
                    idle_cnt_reg <= idle_cnt_reg + 4'h1;
                end
            end else begin
                sec_cnt_reg <= sec_cnt_reg + 32'h1;
            end
        end
    end

    // Mode sequencer; sleep command outranks touch and idle, wake only from Sleep
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_reg <= tpm_pkg::TPM_NORMAL;
        end else if (clk_en) begin
            case (mode_reg)
                tpm_pkg::TPM_NORMAL: begin
                    if (sleep_cmd) begin
                        mode_reg <= tpm_pkg::TPM_SLEEP;
                    end else if (!(scan_done && touch_seen) && idle_cnt_reg >= idle_secs) begin
                        mode_reg <= tpm_pkg::TPM_GREEN;
                    end
                end
                tpm_pkg::TPM_GREEN: begin
                    if (sleep_cmd) begin
                        mode_reg <= tpm_pkg::TPM_SLEEP;
                    end else if (scan_done && touch_seen) begin
                        mode_reg <= tpm_pkg::TPM_NORMAL;
                    end
                end
                tpm_pkg::TPM_SLEEP: begin
                    if (wake_fire) begin
                        mode_reg <= tpm_pkg::TPM_NORMAL;
                    end
                end
                default: mode_reg <= tpm_pkg::TPM_NORMAL;
            endcase
        end
    end

    // Touch events only, never while asleep
    assign notify = scan_done && touch_seen && (mode_reg != tpm_pkg::TPM_SLEEP);

    // Notification pulse: idle level set by trigger, pulse is the active edge then return
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pulse_cnt_reg <= 5'h0;
        end else if (clk_en) begin
            if (mode_reg == tpm_pkg::TPM_SLEEP) begin
                pulse_cnt_reg <= 5'h0;
            end else if (notify) begin
                pulse_cnt_reg <= 5'(`TPM_INT_PULSE_CYC);
            end else if (pulse_cnt_reg != 5'h0) begin
                pulse_cnt_reg <= pulse_cnt_reg - 5'h1;
            end
        end
    end

    // Pin released in Sleep so the host may hold it low and drive the wake pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_out <= 1'b0;
            int_oe  <= 1'b0;
        end else if (clk_en) begin
            // Releasing the pin lets the host hold it low, then pulse it to wake us
            int_oe  <= (mode_reg != tpm_pkg::TPM_SLEEP);
            int_out <= int_trigger ^ (pulse_cnt_reg != 5'h0);
        end
    end

    // Frequency hopping after a run of noisy scans
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            noise_cnt_reg <= 2'h0;
            drive_freq    <= '0;
        end else if (clk_en && scan_done) begin
            if (!noise_hit) begin
                noise_cnt_reg <= 2'h0;
            end else if (noise_cnt_reg >= 2'(`TPM_HOP_NOISE_LIM) - 2'h1) begin
                noise_cnt_reg <= 2'h0;
                drive_freq    <= drive_freq + 1'b1;
            end else begin
                noise_cnt_reg <= noise_cnt_reg + 2'h1;
            end
        end
    end

    // Baseline: copy during init window, then slow drift tracking on touch-free scans
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            init_cnt_reg <= 32'h0;
            base_ready   <= 1'b0;
            baseline     <= '0;
        end else if (clk_en) begin
            if (init_cnt_reg < 32'(BASE_INIT_CYC)) begin
                init_cnt_reg <= init_cnt_reg + 32'h1;
            end
            if (scan_done && !touch_seen && !base_ready) begin
                baseline   <= sample_raw;
                base_ready <= 1'b1;
            end else if (!base_ready && init_cnt_reg >= 32'(BASE_INIT_CYC) - 32'h1) begin
                base_ready <= 1'b1;
            end else if (scan_done && !touch_seen) begin
                if (sample_raw > baseline) begin
                    baseline <= baseline + 1'b1;
                end else if (sample_raw < baseline) begin
                    baseline <= baseline - 1'b1;
                end
            end
        end
    end

    // Checks
    // Period checks watch the counter and the request pulse, not the limit mux,
    // so a wrong compare or a lost pulse is caught
    property p_green_period;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && mode_reg == tpm_pkg::TPM_GREEN && scan_cnt_reg == 32'(GREEN_CYC) - 32'h1) |=> scan_start;
    endproperty
    a_green_period: assert property (p_green_period) else $error("green period wrong");

    property p_norm_period;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && mode_reg == tpm_pkg::TPM_NORMAL &&
         scan_cnt_reg == 32'(NORM_MIN_CYC) + 32'(NORM_STEP_CYC) * 32'(scan_period) - 32'h1) |=> scan_start;
    endproperty
    a_norm_period: assert property (p_norm_period) else $error("normal period wrong");

    // Third noisy scan in a row must move the drive frequency
    property p_hop;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && scan_done && noise_hit && noise_cnt_reg == 2'(`TPM_HOP_NOISE_LIM - 1))
        |=> drive_freq != $past(drive_freq);
    endproperty
    a_hop: assert property (p_hop) else $error("no frequency hop");

    property p_sleep_enter;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && sleep_cmd && mode_reg != tpm_pkg::TPM_SLEEP) |=> mode_reg == tpm_pkg::TPM_SLEEP;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_green_wake;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && !sleep_cmd && mode_reg == tpm_pkg::TPM_GREEN && scan_done && touch_seen)
        |=> mode_reg == tpm_pkg::TPM_NORMAL;
    endproperty
    a_green_wake: assert property (p_green_wake) else $error("green touch ignored");

    // Gated by clk_en: a frozen cycle keeps the last drive values
    property p_sleep_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && mode_reg == tpm_pkg::TPM_SLEEP) |=> !scan_start && !int_oe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

    property p_wake;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && wake_fire) |=> mode_reg == tpm_pkg::TPM_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");

    property p_notify_only_touch;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && $rose(pulse_cnt_reg != 5'h0)) |-> $past(notify);
    endproperty
    a_notify_only_touch: assert property (p_notify_only_touch) else $error("spurious notify");

    property p_idle_level;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && $past(clk_en) && $past(pulse_cnt_reg) == 5'h0) |-> int_out == $past(int_trigger);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("int idle level wrong");

    property p_base_init;
        @(posedge core_clk) disable iff (sys_rst)
        (init_cnt_reg >= 32'(BASE_INIT_CYC)) |-> base_ready;
    endproperty
    a_base_init: assert property (p_base_init) else $error("baseline late");

endmodule

/* File: bench/tpm_host_model.sv */
// Host side of the interrupt pin: pulls it low ahead of sleep, pulses it high to wake.
// Assumes the device releases the pin while asleep; host_clk is the 80 ns host timer.
`timescale 1ns/1ps
module tpm_host_model (
    input  wire logic host_clk, // Host timer clock
    input  wire logic dev_out,  // Device drive value
    input  wire logic dev_oe,   // Device drive enable
    output logic      pin       // Resolved pin level
);
    logic host_oe;  // Host drives the pin
    logic host_val; // Host drive value
    logic last_pin; // Last level, shown inverted when undriven
    // No pull on the line, so an undriven pin must not keep a stale level
    assign pin = dev_oe ? dev_out : (host_oe ? host_val : ~last_pin);
    initial begin
        host_oe = 1'b0;
        host_val = 1'b0;
        last_pin = 1'b0;
    end
    // Track the level for the undriven case
    always @(posedge host_clk) last_pin <= pin;
    // Host lets go once the device takes the pin back
    always @(posedge dev_oe) host_oe <= 1'b0;
    // Low before the sleep command
    task automatic drive_low();
        @(posedge host_clk);
        host_oe = 1'b1;
        host_val = 1'b0;
    endtask
    // High for n timer ticks, then low again
    task automatic wake(input int n);
        @(posedge host_clk);
        host_val = 1'b1;
        repeat (n) @(posedge host_clk);
        host_val = 1'b0;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the touch power-mode block with shortened counts.
// Assumes the host model on the pin; clk_en is dropped in one scenario only.
`timescale 1ns/1ps
module tb_top;
    logic        core_clk, sys_rst, clk_en, link_clk, int_trigger, sleep_cmd;
    logic        scan_done, touch_seen, noise_hit, int_in, int_out, int_oe;
    logic        scan_start, base_ready;
    logic [1:0]  scan_period, mode_out;
    logic [3:0]  idle_secs;
    logic [2:0]  drive_freq, f0;
    logic [15:0] sample_raw, baseline, b0;
    int          err_total, checked, n;
    // Shortened counts so every mode change fits a short run
    localparam int NORM_MIN  = 70;
    localparam int NORM_STEP = 10;
    localparam int GREEN     = 400;
    localparam int SEC       = 100;
    localparam int WAKE_MIN  = 20;
    localparam int WAKE_MAX  = 50;
    localparam int BASE_INIT = 2000;
    tpm_power_notify #(.NORM_MIN_CYC(NORM_MIN), .NORM_STEP_CYC(NORM_STEP), .GREEN_CYC(GREEN), .SEC_CYC(SEC),
        .WAKE_MIN_CYC(WAKE_MIN), .WAKE_MAX_CYC(WAKE_MAX), .BASE_INIT_CYC(BASE_INIT)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .scan_period(scan_period),
        .idle_secs(idle_secs), .int_trigger(int_trigger), .sleep_cmd(sleep_cmd),
        .scan_done(scan_done), .touch_seen(touch_seen), .noise_hit(noise_hit),
        .sample_raw(sample_raw), .int_in(int_in), .int_out(int_out), .int_oe(int_oe),
        .scan_start(scan_start), .drive_freq(drive_freq), .baseline(baseline),
        .base_ready(base_ready), .mode_out(mode_out));
    tpm_host_model host (.host_clk(link_clk), .dev_out(int_out), .dev_oe(int_oe), .pin(int_in));
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    // Host timer, offset so its edges never line up with the core clock
    initial begin
        link_clk = 1'b0;
        #13.3;
        forever #40 link_clk = ~link_clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One-cycle scan result, then one cycle for the answer to land
    task automatic scan(input logic t, input logic z, input logic [15:0] s);
        @(negedge core_clk);
        scan_done  = 1'b1;
        touch_seen = t;
        noise_hit  = z;
        sample_raw = s;
        @(negedge core_clk);
        scan_done = 1'b0;
        @(negedge core_clk);
    endtask
    // Cycles between two scan requests, bounded
    task automatic gap(output int c);
        c = 0;
        while (scan_start !== 1'b1 && c < 1000) begin
            @(negedge core_clk);
            c++;
        end
        @(negedge core_clk);
        c = 1;
        while (scan_start !== 1'b1 && c < 1000) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    task automatic t_base();
        chk("mode_rst", mode_out, tpm_pkg::TPM_NORMAL);
        scan(1'b0, 1'b0, 16'h1234);
        chk("base_ready", base_ready, 1'b1);
        chk("base_first", baseline, 16'h1234);
        scan(1'b0, 1'b0, 16'h2000);
        chk("base_up", baseline, 16'h1235);
        scan(1'b1, 1'b0, 16'h0000);
        chk("base_touch", baseline, 16'h1235);
        scan(1'b0, 1'b0, 16'h1000);
        chk("base_down", baseline, 16'h1234);
    endtask
    task automatic t_notify();
        for (int i = 0; i < 2; i++) begin
            int_trigger = i[0];
            repeat (20) @(negedge core_clk);
            chk("int_idle", int_out, int_trigger);
            scan(1'b0, 1'b0, 16'h1234);
            chk("int_quiet", int_out, int_trigger);
            scan(1'b1, 1'b0, 16'h1234);
            chk("int_active", int_out, !int_trigger);
            repeat (12) @(negedge core_clk);
            chk("int_held", int_out, !int_trigger);
            repeat (6) @(negedge core_clk);
            chk("int_back", int_out, int_trigger);
        end
        int_trigger = 1'b0;
    endtask
    task automatic t_hop();
        f0 = drive_freq;
        repeat (2) scan(1'b0, 1'b1, 16'h1234);
        chk("hop_early", drive_freq, f0);
        scan(1'b0, 1'b1, 16'h1234);
        chk("hop_moved", drive_freq == f0, 1'b0);
    endtask
    task automatic t_period();
        for (int p = 0; p < 4; p++) begin
            scan_period = p[1:0];
            scan(1'b1, 1'b0, 16'h1234);
            gap(n);
            gap(n);
            chk("norm_period", 16'(n), 16'(NORM_MIN + NORM_STEP * p));
        end
    endtask
    task automatic t_green();
        idle_secs = 4'h1;
        scan(1'b1, 1'b0, 16'h1234);
        n = 0;
        while (mode_out !== tpm_pkg::TPM_GREEN && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        chk("green_entry", n >= SEC - 10 && n <= SEC + 5, 1'b1);
        gap(n);
        gap(n);
        chk("green_period", 16'(n), 16'(GREEN));
        scan(1'b1, 1'b0, 16'h1234);
        chk("green_exit", mode_out, tpm_pkg::TPM_NORMAL);
        idle_secs = 4'hf;
    endtask
    task automatic t_sleep();
        host.drive_low();
        @(negedge core_clk);
        sleep_cmd = 1'b1;
        @(negedge core_clk);
        sleep_cmd = 1'b0;
        @(negedge core_clk);
        chk("sleep_mode", mode_out, tpm_pkg::TPM_SLEEP);
        scan(1'b1, 1'b0, 16'h1234);
        chk("sleep_oe", int_oe, 1'b0);
        n = 0;
        repeat (200) begin
            @(negedge core_clk);
            n += (scan_start === 1'b1);
        end
        chk("sleep_scans", 16'(n), 16'd0);
        host.wake(1);
        repeat (40) @(negedge core_clk);
        chk("wake_short", mode_out, tpm_pkg::TPM_SLEEP);
        host.wake(4);
        repeat (40) @(negedge core_clk);
        chk("wake_long", mode_out, tpm_pkg::TPM_SLEEP);
        host.wake(2);
        n = 0;
        while (mode_out !== tpm_pkg::TPM_NORMAL && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        chk("wake_ok", mode_out, tpm_pkg::TPM_NORMAL);
        repeat (3) @(negedge core_clk);
        chk("wake_oe", int_oe, 1'b1);
    endtask
    // Touch and noise while clk_en is low must leave int_out, drive_freq and baseline as they were
    task automatic t_freeze();
        f0 = drive_freq;
        b0 = baseline;
        clk_en = 1'b0;
        repeat (3) scan(1'b1, 1'b1, 16'hffff);
        chk("frz_int", int_out, 1'b0);
        chk("frz_freq", drive_freq, f0);
        chk("frz_base", baseline, b0);
        clk_en = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("frz_after", int_out, 1'b0);
    endtask
    // Mid-run reset with no touch-free scan: baseline ready only when the window ends
    task automatic t_reset();
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("rst_ready", base_ready, 1'b0);
        chk("rst_mode", mode_out, tpm_pkg::TPM_NORMAL);
        sys_rst = 1'b0;
        n = 0;
        while (base_ready !== 1'b1 && n < BASE_INIT + 100) begin
            @(negedge core_clk);
            n++;
        end
        chk("base_window", 16'(n), 16'(BASE_INIT));
        chk("base_none", baseline, 16'h0000);
    endtask
    // Cuts a hang well past the expected few thousand cycles
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    // Reset, then every scenario in turn
    initial begin
        core_clk    = 1'b0;
        sys_rst     = 1'b1;
        clk_en      = 1'b1;
        int_trigger = 1'b0;
        sleep_cmd   = 1'b0;
        scan_done   = 1'b0;
        touch_seen  = 1'b0;
        noise_hit   = 1'b0;
        sample_raw  = 16'h0000;
        scan_period = 2'h0;
        idle_secs   = 4'hf;
        err_total   = 0;
        checked     = 0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_base();
        t_notify();
        t_hop();
        t_period();
        t_green();
        t_sleep();
        t_freeze();
        t_reset();
        report_and_stop();
    end
endmodule
